// File: core/dtio_pkg.sv
// shared constants and carrier types of the drive terminal i/o select block
package dtio_pkg;

	// clock and time bases
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned TICK_MS = 100;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned SEQ_PULSE_MS = 250;
	localparam int unsigned SEQ_PULSE_CYCLES = CLK_HZ / 1000 * SEQ_PULSE_MS;
	localparam int unsigned OVL_WARN_S = 10;
	localparam logic [15:0] OVL_WARN_TICKS = 16'(OVL_WARN_S * 1000 / TICK_MS);
	localparam int unsigned FAST_MAX_HZ = 100_000;
	localparam logic [15:0] FAST_MIN_HALF = 16'(CLK_HZ / (2 * FAST_MAX_HZ));
	localparam logic [15:0] DELAY_MAX_TICKS = 16'h8ca0;

	// register indices
	localparam logic [3:0] REG_BELOW_MIN = 4'h0;
	localparam logic [3:0] REG_POLARITY = 4'h1;
	localparam logic [3:0] REG_DELAY_FIRST = 4'h2;
	localparam logic [3:0] REG_DELAY_SECOND = 4'h3;
	localparam logic [3:0] REG_DELAY_THIRD = 4'h4;
	localparam logic [3:0] REG_FAST_MODE = 4'h5;
	localparam logic [3:0] REG_OC_CODE = 4'h6;
	localparam logic [3:0] REG_RELAY_CODE = 4'h7;
	localparam logic [3:0] REG_SET_COUNT = 4'h8;
	localparam logic [3:0] REG_DESIG_COUNT = 4'h9;
	localparam logic [3:0] REG_TARGET_LEN = 4'ha;
	localparam logic [3:0] REG_STATUS = 4'hb;

	// reset values
	localparam logic [11:0] BELOW_MIN_RST = 12'h000;
	localparam logic [19:0] POLARITY_RST = 20'h00000;
	localparam logic [15:0] DELAY_RST = 16'h0000;
	localparam logic FAST_MODE_RST = 1'b0;
	localparam logic [5:0] OC_CODE_RST = 6'h00;
	localparam logic [5:0] RELAY_CODE_RST = 6'h02;

	// field layout: one bcd nibble per digit
	localparam int unsigned DIGIT_W = 4;
	localparam logic [15:0] ZERO_PCT = 16'h0000;

	// fast output modes
	localparam logic MODE_PULSE = 1'b0;
	localparam logic MODE_SWITCH = 1'b1;

	// output function codes
	localparam logic [5:0] FN_NONE = 6'h00;
	localparam logic [5:0] FN_RUNNING = 6'h01;
	localparam logic [5:0] FN_FAULT_STOP = 6'h02;
	localparam logic [5:0] FN_ZERO_SPEED = 6'h05;
	localparam logic [5:0] FN_OVL_WARN = 6'h07;
	localparam logic [5:0] FN_SET_COUNT = 6'h08;
	localparam logic [5:0] FN_DESIG_COUNT = 6'h09;
	localparam logic [5:0] FN_LENGTH = 6'h0a;
	localparam logic [5:0] FN_SEQ_CYCLE = 6'h0b;
	localparam logic [5:0] FN_FREQ_LIMIT = 6'h0d;
	localparam logic [5:0] FN_AI_COMPARE = 6'h10;
	localparam logic [5:0] FN_UPPER_LIMIT = 6'h11;

	typedef struct packed {
		logic [15:0] curve_value;
		logic [15:0] min_setting;
		logic below_min;
	} dtio_analog_t;

	typedef struct packed {
		logic running;
		logic zero_freq;
		logic fault_stop;
		logic overload_active;
		logic [15:0] overload_eta;
		logic [31:0] count_value;
		logic [31:0] length_value;
		logic seq_cycle_done;
		logic cmd_beyond_upper;
		logic cmd_beyond_lower;
		logic at_upper;
		logic at_lower;
		logic [15:0] pulse_half_period;
	} dtio_drive_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} dtio_bus_t;

endpackage

// File: core/dtio_top.sv
// terminal input conditioning and output function selection
//
// Contract
// - digit 0: below-min uses curve min setting
// - digit 1: below-min forces zero percent
// - one decimal digit per analog channel
// - input change delay 0.0 to 3600.0 s
// - delay only on inputs one to three
// - polarity digit per input, 0 high, 1 low
// - active high: grounded valid, open invalid
// - active low: grounded invalid, open valid
// - fast output: 0 pulse, 1 switch
// - fast pulse frequency at most 100 kHz
// - per-output code, defaults 0 and 2
// - code 0: output inactive
// - code 1: active while running
// - code 2: active on fault stop
// - code 5: running at zero frequency
// - code 7: ten seconds before overload trip
// - codes 8, 9: count reaches set counts
// - code 10: length exceeds target
// - code 11: 250 ms pulse per sequence
// - code 13: command and output at limit
// - code 16: first analog above second
// - code 17: running at upper limit
// - pulse input only on fifth input
`timescale 1ns/1ps

module dtio_top #(
	parameter int unsigned TICK_LEN = dtio_pkg::TICK_CYCLES,
	parameter int unsigned SEQ_LEN = dtio_pkg::SEQ_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire dtio_pkg::dtio_bus_t bus,
	output logic [31:0] rdata,
	input wire dtio_pkg::dtio_analog_t analog_in_first,
	input wire dtio_pkg::dtio_analog_t analog_in_second,
	input wire dtio_pkg::dtio_analog_t analog_in_third,
	input wire logic digital_in_first,
	input wire logic digital_in_second,
	input wire logic digital_in_third,
	input wire logic digital_in_fourth,
	input wire logic digital_in_fifth,
	input wire dtio_pkg::dtio_drive_t drive,
	output logic [15:0] chan_value_first,
	output logic [15:0] chan_value_second,
	output logic [15:0] chan_value_third,
	output logic [4:0] input_valid,
	output logic fast_pulse_input,
	output logic fast_multiplex_output,
	output logic relay_one_contact
);

	// software registers
	logic [11:0] below_minimum_select_word;
	logic [19:0] input_polarity_word;
	logic [15:0] delay_ticks [3];
	logic fast_output_mode_select;
	logic [5:0] oc_code;
	logic [5:0] relay_code;
	logic [31:0] set_count;
	logic [31:0] desig_count;
	logic [31:0] target_len;

	// bus decode
	wire wr_below = bus.wr && bus.addr == dtio_pkg::REG_BELOW_MIN;
	wire wr_pol = bus.wr && bus.addr == dtio_pkg::REG_POLARITY;
	wire wr_d0 = bus.wr && bus.addr == dtio_pkg::REG_DELAY_FIRST;
	wire wr_d1 = bus.wr && bus.addr == dtio_pkg::REG_DELAY_SECOND;
	wire wr_d2 = bus.wr && bus.addr == dtio_pkg::REG_DELAY_THIRD;
	wire wr_mode = bus.wr && bus.addr == dtio_pkg::REG_FAST_MODE;
	wire wr_oc = bus.wr && bus.addr == dtio_pkg::REG_OC_CODE;
	wire wr_relay = bus.wr && bus.addr == dtio_pkg::REG_RELAY_CODE;
	wire wr_setc = bus.wr && bus.addr == dtio_pkg::REG_SET_COUNT;
	wire wr_desc = bus.wr && bus.addr == dtio_pkg::REG_DESIG_COUNT;
	wire wr_len = bus.wr && bus.addr == dtio_pkg::REG_TARGET_LEN;

	// delays above the range saturate rather than wrap
	wire [15:0] wr_delay = (bus.wdata[15:0] > dtio_pkg::DELAY_MAX_TICKS) ?
		dtio_pkg::DELAY_MAX_TICKS : bus.wdata[15:0];

	always_ff @(posedge clk) begin
		if (srst) begin
			below_minimum_select_word <= dtio_pkg::BELOW_MIN_RST;
			input_polarity_word <= dtio_pkg::POLARITY_RST;
			delay_ticks[0] <= dtio_pkg::DELAY_RST;
			delay_ticks[1] <= dtio_pkg::DELAY_RST;
			delay_ticks[2] <= dtio_pkg::DELAY_RST;
			fast_output_mode_select <= dtio_pkg::FAST_MODE_RST;
			oc_code <= dtio_pkg::OC_CODE_RST;
			relay_code <= dtio_pkg::RELAY_CODE_RST;
			set_count <= '0;
			desig_count <= '0;
			target_len <= '0;
		end else begin
			if (wr_below)
				below_minimum_select_word <= bus.wdata[11:0];
			if (wr_pol)
				input_polarity_word <= bus.wdata[19:0];
			if (wr_d0)
				delay_ticks[0] <= wr_delay;
			if (wr_d1)
				delay_ticks[1] <= wr_delay;
			if (wr_d2)
				delay_ticks[2] <= wr_delay;
			if (wr_mode)
				fast_output_mode_select <= bus.wdata[0];
			if (wr_oc)
				oc_code <= bus.wdata[5:0];
			if (wr_relay)
				relay_code <= bus.wdata[5:0];
			if (wr_setc)
				set_count <= bus.wdata;
			if (wr_desc)
				desig_count <= bus.wdata;
			if (wr_len)
				target_len <= bus.wdata;
		end
	end

	// read mux; unmapped addresses read zero
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = '0;
		if (bus.rd) begin
			unique case (bus.addr)
			dtio_pkg::REG_BELOW_MIN: next_rdata = {20'h0, below_minimum_select_word};
			dtio_pkg::REG_POLARITY: next_rdata = {12'h0, input_polarity_word};
			dtio_pkg::REG_DELAY_FIRST: next_rdata = {16'h0, delay_ticks[0]};
			dtio_pkg::REG_DELAY_SECOND: next_rdata = {16'h0, delay_ticks[1]};
			dtio_pkg::REG_DELAY_THIRD: next_rdata = {16'h0, delay_ticks[2]};
			dtio_pkg::REG_FAST_MODE: next_rdata = {31'h0, fast_output_mode_select};
			dtio_pkg::REG_OC_CODE: next_rdata = {26'h0, oc_code};
			dtio_pkg::REG_RELAY_CODE: next_rdata = {26'h0, relay_code};
			dtio_pkg::REG_SET_COUNT: next_rdata = set_count;
			dtio_pkg::REG_DESIG_COUNT: next_rdata = desig_count;
			dtio_pkg::REG_TARGET_LEN: next_rdata = target_len;
			dtio_pkg::REG_STATUS: next_rdata = {24'h0, relay_one_contact,
				fast_multiplex_output, fast_pulse_input, input_valid};
			default: next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			rdata <= '0;
		else
			rdata <= next_rdata;
	end

	// analog below-minimum substitution, one bcd digit per channel
	dtio_pkg::dtio_analog_t ain [3];
	assign ain[0] = analog_in_first;
	assign ain[1] = analog_in_second;
	assign ain[2] = analog_in_third;
	logic [15:0] chan_next [3];

	genvar a;
	generate
		for (a = 0; a < 3; a++) begin : g_ain
			wire [3:0] digit =
				below_minimum_select_word[a*dtio_pkg::DIGIT_W +: 4];
			// any nonzero digit is taken as the zero-percent choice
			wire zero_sel = digit != 4'h0;
			assign chan_next[a] = !ain[a].below_min ? ain[a].curve_value :
				zero_sel ? dtio_pkg::ZERO_PCT :
				ain[a].min_setting;
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (srst) begin
			chan_value_first <= '0;
			chan_value_second <= '0;
			chan_value_third <= '0;
		end else begin
			chan_value_first <= chan_next[0];
			chan_value_second <= chan_next[1];
			chan_value_third <= chan_next[2];
		end
	end

	// 0.1 s time base shared by the input delays
	logic [31:0] tick_cnt;
	wire tick = tick_cnt == 32'(TICK_LEN - 1);
	always_ff @(posedge clk) begin
		if (srst || tick)
			tick_cnt <= '0;
		else
			tick_cnt <= tick_cnt + 32'h1;
	end

	// digital inputs: polarity then optional change delay
	wire [4:0] pin = {digital_in_fifth, digital_in_fourth, digital_in_third,
		digital_in_second, digital_in_first};
	logic [4:0] accepted;

	genvar d;
	generate
		for (d = 0; d < 5; d++) begin : g_din
			wire low_sel = input_polarity_word[d*dtio_pkg::DIGIT_W +: 4] != 4'h0;
			// pin low means the terminal is tied to ground
			wire valid_now = low_sel ? pin[d] : ~pin[d];
			if (d < 3) begin : g_delay
				logic [15:0] cnt;
				wire [15:0] cnt_inc = cnt + 16'h1;
				wire expire = delay_ticks[d] == 16'h0 ||
					(tick && cnt_inc >= delay_ticks[d]);
				// a level that reverts before expiry restarts the count
				always_ff @(posedge clk) begin
					if (srst) begin
						accepted[d] <= 1'b0;
						cnt <= '0;
					end else if (valid_now == accepted[d]) begin
						cnt <= '0;
					end else if (expire) begin
						accepted[d] <= valid_now;
						cnt <= '0;
					end else if (tick) begin
						cnt <= cnt_inc;
					end
				end
			end else begin : g_direct
				always_ff @(posedge clk) begin
					if (srst)
						accepted[d] <= 1'b0;
					else
						accepted[d] <= valid_now;
				end
			end
		end
	endgenerate

	assign input_valid = accepted;
	// only the fifth input feeds the pulse path
	assign fast_pulse_input = accepted[4];

	// 250 ms one-shot per sequencer cycle; a retrigger restarts it
	logic [31:0] seq_cnt;
	logic seq_pulse;
	always_ff @(posedge clk) begin
		if (srst) begin
			seq_cnt <= '0;
			seq_pulse <= 1'b0;
		end else if (drive.seq_cycle_done) begin
			seq_cnt <= 32'(SEQ_LEN - 1);
			seq_pulse <= 1'b1;
		end else if (seq_cnt != 32'h0) begin
			seq_cnt <= seq_cnt - 32'h1;
		end else begin
			seq_pulse <= 1'b0;
		end
	end

	// status sources shared by all switch outputs
	wire src_running = drive.running;
	wire src_fault = drive.fault_stop;
	wire src_zero = drive.running && drive.zero_freq;
	wire src_ovl = drive.overload_active &&
		drive.overload_eta <= dtio_pkg::OVL_WARN_TICKS;
	wire src_setc = drive.count_value >= set_count;
	wire src_desc = drive.count_value >= desig_count;
	wire src_len = drive.length_value > target_len;
	wire src_lim = (drive.cmd_beyond_upper && drive.at_upper) ||
		(drive.cmd_beyond_lower && drive.at_lower);
	wire src_cmp = $signed(chan_value_first) >
		$signed(chan_value_second);
	wire src_upper = drive.running && drive.at_upper;

	// sources go in as an argument: a continuous assignment only
	// re-evaluates on its operands, not on what a function reads inside
	wire [10:0] src_vec = {src_upper, src_cmp, src_lim, seq_pulse, src_len,
		src_desc, src_setc, src_ovl, src_zero, src_fault, src_running};

	function automatic logic fn_select(input logic [5:0] code,
		input logic [10:0] s);
		logic r;
		r = 1'b0;
		case (code)
		dtio_pkg::FN_RUNNING: r = s[0];
		dtio_pkg::FN_FAULT_STOP: r = s[1];
		dtio_pkg::FN_ZERO_SPEED: r = s[2];
		dtio_pkg::FN_OVL_WARN: r = s[3];
		dtio_pkg::FN_SET_COUNT: r = s[4];
		dtio_pkg::FN_DESIG_COUNT: r = s[5];
		dtio_pkg::FN_LENGTH: r = s[6];
		dtio_pkg::FN_SEQ_CYCLE: r = s[7];
		dtio_pkg::FN_FREQ_LIMIT: r = s[8];
		dtio_pkg::FN_AI_COMPARE: r = s[9];
		dtio_pkg::FN_UPPER_LIMIT: r = s[10];
		default: r = 1'b0;
		endcase
		return r;
	endfunction

	wire oc_active = fn_select(oc_code, src_vec);
	wire relay_active = fn_select(relay_code, src_vec);

	// pulse generator; half period clamped so rate never passes 100 kHz
	wire [15:0] half = (drive.pulse_half_period < dtio_pkg::FAST_MIN_HALF) ?
		dtio_pkg::FAST_MIN_HALF : drive.pulse_half_period;
	logic [15:0] pulse_cnt;
	logic pulse_level;
	wire pulse_flip = pulse_cnt + 16'h1 >= half;
	always_ff @(posedge clk) begin
		if (srst || fast_output_mode_select == dtio_pkg::MODE_SWITCH) begin
			pulse_cnt <= '0;
			pulse_level <= 1'b0;
		end else if (pulse_flip) begin
			pulse_cnt <= '0;
			pulse_level <= ~pulse_level;
		end else begin
			pulse_cnt <= pulse_cnt + 16'h1;
		end
	end

	wire next_fast = (fast_output_mode_select == dtio_pkg::MODE_SWITCH) ?
		oc_active : pulse_level;

	always_ff @(posedge clk) begin
		if (srst) begin
			fast_multiplex_output <= 1'b0;
			relay_one_contact <= 1'b0;
		end else begin
			fast_multiplex_output <= next_fast;
			relay_one_contact <= relay_active;
		end
	end

endmodule

// File: testbench/dtio_sva.sv
// port assertions for the terminal i/o select block
`timescale 1ns/1ps
module dtio_sva #(
	parameter int unsigned TICK_LEN = 10,
	parameter int unsigned SEQ_LEN = 20
) (
	input wire logic clk,
	input wire logic srst,
	input wire dtio_pkg::dtio_bus_t bus,
	input wire logic [31:0] rdata,
	input wire dtio_pkg::dtio_analog_t analog_in_first,
	input wire dtio_pkg::dtio_analog_t analog_in_second,
	input wire dtio_pkg::dtio_analog_t analog_in_third,
	input wire logic digital_in_fourth,
	input wire logic digital_in_fifth,
	input wire dtio_pkg::dtio_drive_t drive,
	input wire logic [15:0] chan_value_first,
	input wire logic [15:0] chan_value_second,
	input wire logic [15:0] chan_value_third,
	input wire logic [4:0] input_valid,
	input wire logic fast_pulse_input,
	input wire logic fast_multiplex_output,
	input wire logic relay_one_contact
);
	logic [19:0] pol;
	logic [11:0] bm;
	logic [5:0] oc, rc;
	logic [15:0] cnt, e1, e2, e3;
	logic [1:0] fr, fo;
	logic mode, oq, arm, e4, e5;
	// known flag in bit 1: codes with counters are left to the bench
	function automatic logic [1:0] fx(logic [5:0] c,
		dtio_pkg::dtio_drive_t d);
		case (c)
		dtio_pkg::FN_NONE: return 2'b10;
		dtio_pkg::FN_RUNNING: return {1'b1, d.running};
		dtio_pkg::FN_FAULT_STOP: return {1'b1, d.fault_stop};
		dtio_pkg::FN_ZERO_SPEED: return {1'b1, d.running & d.zero_freq};
		dtio_pkg::FN_OVL_WARN: return {1'b1, d.overload_active &&
			d.overload_eta <= dtio_pkg::OVL_WARN_TICKS};
		dtio_pkg::FN_FREQ_LIMIT: return {1'b1, d.cmd_beyond_upper &
			d.at_upper | d.cmd_beyond_lower & d.at_lower};
		dtio_pkg::FN_UPPER_LIMIT: return {1'b1, d.running & d.at_upper};
		default: return 2'b00;
		endcase
	endfunction
	function automatic logic [15:0] ch(dtio_pkg::dtio_analog_t a,
		logic [3:0] g);
		if (!a.below_min) return a.curve_value;
		return g != 4'h0 ? dtio_pkg::ZERO_PCT : a.min_setting;
	endfunction
	assign fr = fx(rc, drive);
	assign fo = fx(oc, drive);
	assign e1 = ch(analog_in_first, bm[3:0]);
	assign e2 = ch(analog_in_second, bm[7:4]);
	assign e3 = ch(analog_in_third, bm[11:8]);
	assign e4 = pol[15:12] != 4'h0 ? digital_in_fourth : ~digital_in_fourth;
	assign e5 = pol[19:16] != 4'h0 ? digital_in_fifth : ~digital_in_fifth;
	// shadow of the select, polarity, mode and code words, same write timing as the block
	always_ff @(posedge clk) begin
		if (srst) begin
			pol <= dtio_pkg::POLARITY_RST;
			bm <= dtio_pkg::BELOW_MIN_RST;
			mode <= dtio_pkg::FAST_MODE_RST;
			oc <= dtio_pkg::OC_CODE_RST;
			rc <= dtio_pkg::RELAY_CODE_RST;
		end else if (bus.wr) begin
			case (bus.addr)
			dtio_pkg::REG_BELOW_MIN: bm <= bus.wdata[11:0];
			dtio_pkg::REG_POLARITY: pol <= bus.wdata[19:0];
			dtio_pkg::REG_FAST_MODE: mode <= bus.wdata[0];
			dtio_pkg::REG_OC_CODE: oc <= bus.wdata[5:0];
			dtio_pkg::REG_RELAY_CODE: rc <= bus.wdata[5:0];
			default: ;
			endcase
		end
	end
	// gap since last toggle; a mode change may cut a half short, so disarm
	always_ff @(posedge clk) begin
		oq <= fast_multiplex_output;
		if (srst || mode) begin
			arm <= 1'b0;
			cnt <= 16'h0000;
		end else if (fast_multiplex_output != oq) begin
			arm <= 1'b1;
			cnt <= 16'h0001;
		end else if (cnt != 16'hffff) begin
			cnt <= cnt + 16'h0001;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_chan_select: assert property (!$past(srst) |->
		chan_value_first == $past(e1) && chan_value_second == $past(e2) &&
		chan_value_third == $past(e3)) else $error("channel value wrong");
	a_direct_inputs: assert property (!$past(srst) |->
		input_valid[4:3] == $past({e5, e4}) && fast_pulse_input ==
		$past(e5)) else $error("undelayed input wrong");
	a_relay_func: assert property (!$past(srst) && $past(fr[1]) |->
		relay_one_contact == $past(fr[0])) else $error("relay wrong");
	a_oc_switch: assert property (!$past(srst) && $past(mode) &&
		$past(fo[1]) |-> fast_multiplex_output == $past(fo[0]))
		else $error("switch output wrong");
	a_ai_compare: assert property ($past(rc) ==
		dtio_pkg::FN_AI_COMPARE && !$past(srst) |-> relay_one_contact ==
		($past($signed(chan_value_first)) > $past($signed(chan_value_second))))
		else $error("compare output wrong");
	a_seq_width: assert property ($rose(relay_one_contact) &&
		rc == dtio_pkg::FN_SEQ_CYCLE && $past(rc) == dtio_pkg::FN_SEQ_CYCLE
		|-> relay_one_contact [*8]) else $error("sequence pulse short");
	a_pulse_gap: assert property (arm && fast_multiplex_output != oq |->
		cnt >= dtio_pkg::FAST_MIN_HALF) else $error("pulse too fast");
	a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
		else $error("read data outside read");
	a_status_read: assert property ($past(bus.rd && bus.addr ==
		dtio_pkg::REG_STATUS) && !$past(srst) |-> rdata == {24'h0,
		$past(relay_one_contact), $past(fast_multiplex_output),
		$past(fast_pulse_input), $past(input_valid)})
		else $error("status word wrong");
endmodule
bind dtio_top dtio_sva #(.TICK_LEN(TICK_LEN), .SEQ_LEN(SEQ_LEN)) u_dtio_sva (.*);

// File: testbench/dtio_field.sv
// field wiring: switches to ground and a load counting output edges
`timescale 1ns/1ps
module dtio_field (
	input wire logic clk,
	input wire logic [4:0] closed,
	input wire logic fast,
	output logic [4:0] pin,
	output int edges
);
	logic last;
	// open contact rests at the pull-up level
	assign pin = ~closed;
	initial edges = 0;
	always @(posedge clk) begin
		last <= fast;
		if (fast != last) edges <= edges + 1;
	end
endmodule

// File: testbench/tb.sv
// bench with reference model for dtio_top
`timescale 1ns/1ps
module tb;
	localparam int TK = 10;
	localparam int SQ = 20;
	logic clk, srst, fpi, fo, ro;
	dtio_pkg::dtio_bus_t bus;
	dtio_pkg::dtio_analog_t a1, a2, a3;
	dtio_pkg::dtio_drive_t drive, d;
	logic [31:0] rdata, rv, pl, bm, st, dg, tl;
	logic [15:0] c1, c2, c3;
	logic [4:0] input_valid, sw, pin, e;
	int err_count, n_tests, ed, hc, k, j, x;
	int cl[12] = '{0, 1, 2, 5, 7, 8, 9, 10, 13, 16, 17, 3};
	int hp[2] = '{50, 250};
	dtio_top #(.TICK_LEN(TK), .SEQ_LEN(SQ)) u_dtio_top (.clk, .srst,
		.bus, .rdata, .analog_in_first(a1), .analog_in_second(a2),
		.analog_in_third(a3), .digital_in_first(pin[0]),
		.digital_in_second(pin[1]), .digital_in_third(pin[2]),
		.digital_in_fourth(pin[3]), .digital_in_fifth(pin[4]), .drive,
		.chan_value_first(c1), .chan_value_second(c2),
		.chan_value_third(c3), .input_valid, .fast_pulse_input(fpi),
		.fast_multiplex_output(fo), .relay_one_contact(ro));
	dtio_field u_dtio_field (.clk, .closed(sw), .fast(fo), .pin, .edges(ed));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) hc <= hc + int'(ro);
	task automatic step(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(logic [3:0] a, logic [31:0] v);
		bus.addr <= a;
		bus.wdata <= v;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(logic [3:0] a);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 rv = rdata;
		@(posedge clk);
	endtask
	task automatic chk(logic [31:0] g, logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			err_count++;
			$display("[ERR] %0t got %h want %h", $time, g, x);
		end
	endtask
	task automatic p();
		drive.seq_cycle_done <= 1'b1;
		@(posedge clk);
		drive.seq_cycle_done <= 1'b0;
	endtask
	task automatic end_sim();
		if (err_count == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	function automatic logic [15:0] mch(dtio_pkg::dtio_analog_t a,
		logic [31:0] g);
		if (!a.below_min) return a.curve_value;
		return g != 0 ? 16'h0000 : a.min_setting;
	endfunction
	function automatic logic mfn(int c);
		case (c)
		1: return drive.running;
		2: return drive.fault_stop;
		5: return drive.running & drive.zero_freq;
		7: return drive.overload_active && drive.overload_eta <= 100;
		8: return drive.count_value >= st;
		9: return drive.count_value >= dg;
		10: return drive.length_value > tl;
		13: return drive.cmd_beyond_upper & drive.at_upper |
			drive.cmd_beyond_lower & drive.at_lower;
		16: return $signed(a1.curve_value) > $signed(a2.curve_value);
		17: return drive.running & drive.at_upper;
		default: return 1'b0;
		endcase
	endfunction
	initial begin
		#1250000;
		err_count++;
		end_sim();
	end
	initial begin
		x = $urandom(32'hfb33);
		srst = 1'b1;
		bus = '0;
		a1 = '0;
		a2 = '0;
		a3 = '0;
		drive = '0;
		sw = 5'h00;
		step(4);
		srst <= 1'b0;
		step(1);
		wr(4'hc, 32'hffffffff);
		for (k = 0; k < 16; k++) begin
			rd(k[3:0]);
			chk(rv & 32'hffffffbf, k == 7 ? 32'h2 : 32'h0);
		end
		// toggle count, phase of the window may add or drop one edge
		for (k = 0; k < 2; k++) begin
			drive.pulse_half_period <= 16'(hp[k]);
			step(600);
			x = ed;
			step(3000);
			j = 3000 / (hp[k] > 200 ? hp[k] : 200);
			chk(32'(ed - x >= j - 1 && ed - x <= j + 1), 32'h1);
		end
		for (k = 0; k < 24; k++) begin
			bm = $urandom & 32'h111;
			wr(dtio_pkg::REG_BELOW_MIN, bm);
			a1 <= {$urandom, 1'($urandom)};
			a2 <= {$urandom, 1'($urandom)};
			a3 <= {$urandom, 1'($urandom)};
			step(2);
			chk(c1, mch(a1, bm & 32'h1));
			chk(c2, mch(a2, bm & 32'h10));
			chk(c3, mch(a3, bm & 32'h100));
		end
		for (k = 0; k < 16; k++) begin
			pl = $urandom & 32'h11111;
			wr(dtio_pkg::REG_POLARITY, pl);
			sw <= 5'($urandom);
			step(3);
			for (j = 0; j < 5; j++) e[j] = pl[4 * j] ? ~sw[j] : sw[j];
			chk(input_valid, e);
			chk(fpi, e[4]);
			rd(dtio_pkg::REG_STATUS);
			chk(rv[4:0], e);
		end
		wr(dtio_pkg::REG_DELAY_FIRST, 32'hffff);
		rd(dtio_pkg::REG_DELAY_FIRST);
		chk(rv, 32'(dtio_pkg::DELAY_MAX_TICKS));
		wr(dtio_pkg::REG_DELAY_FIRST, 32'h3);
		wr(dtio_pkg::REG_POLARITY, 32'h0);
		sw <= 5'h00;
		step(40);
		sw <= 5'h09;
		step(2);
		chk(input_valid, 5'h08);
		step(2 * TK - 4);
		chk(input_valid, 5'h08);
		step(TK + 5);
		chk(input_valid, 5'h09);
		sw <= 5'h08;
		step(TK);
		sw <= 5'h09;
		step(4 * TK);
		chk(input_valid, 5'h09);
		wr(dtio_pkg::REG_FAST_MODE, 32'h1);
		st = $urandom_range(40);
		dg = $urandom_range(40);
		tl = $urandom_range(40);
		wr(dtio_pkg::REG_SET_COUNT, st);
		wr(dtio_pkg::REG_DESIG_COUNT, dg);
		wr(dtio_pkg::REG_TARGET_LEN, tl);
		for (k = 0; k < 12; k++) begin
			wr(dtio_pkg::REG_OC_CODE, 32'(cl[k]));
			wr(dtio_pkg::REG_RELAY_CODE, 32'(cl[k]));
			for (j = 0; j < 25; j++) begin
				d = 105'({$urandom, $urandom, $urandom, $urandom});
				d.overload_eta = 16'($urandom_range(110, 90));
				d.count_value = $urandom_range(63);
				d.length_value = $urandom_range(63);
				d.seq_cycle_done = 1'b0;
				drive <= d;
				a1 <= {$urandom, 1'b0};
				a2 <= {$urandom, 1'b0};
				step(3);
				chk(fo, mfn(cl[k]));
				chk(ro, mfn(cl[k]));
			end
		end
		wr(dtio_pkg::REG_RELAY_CODE, 32'(dtio_pkg::FN_SEQ_CYCLE));
		for (k = 0; k < 2; k++) begin
			x = hc;
			p();
			if (k == 1) step(6);
			if (k == 1) p();
			step(3 * SQ);
			chk(32'(hc - x), 32'(SQ + 7 * k));
		end
		end_sim();
	end
endmodule
